/* File: rtl/iorx_frame_builder.sv */
// Builds the framed I/O sample indication byte stream for the host port.
// Assumes sample source, byte sink and APB share clk_i; no synchronisers.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module iorx_frame_builder
   import iorx_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   // Sample input
   input  wire logic          sample_valid_i,
   input  wire iorx_sample_t  sample_i,
   output var  logic          sample_ready_o,
   // Serial byte stream
   output var  logic          tx_valid_o,
   output var  logic [7:0]    tx_data_o,
   input  wire logic          tx_ready_i,
   // APB
   input  wire iorx_apb_req_t apb_i,
   output var  iorx_apb_rsp_t apb_o
);
   typedef enum logic {ST_IDLE, ST_SEND} iorx_state_t;

   iorx_state_t      state_reg;
   iorx_sample_t     smp_reg;
   logic [4:0][15:0] alist_reg;
   logic [7:0]       len_reg;
   logic [5:0]       pos_reg;
   logic [5:0]       out_pos_reg;
   logic [7:0]       sum_reg;
   logic             mode_reg;
   logic [7:0]       opt_reg;
   logic [31:0]      frames_reg;
   logic [31:0]      drops_reg;
   logic             enabled;
   logic             accept;
   logic             load;
   logic [5:0]       last_pos;
   logic [7:0]       next_byte;
   iorx_sample_t     clean;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == A_CTRL) || (a == A_STATUS) ||
               (a == A_FRAMES) || (a == A_DROPS);
   endfunction

   function automatic logic [2:0] ana_count(input logic [7:0] m);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < NUM_ACH; i++) begin
         if (m[(i == SUPPLY_SLOT) ? SUPPLY_BIT : i]) begin
            c = c + 3'h1;
         end
      end
      ana_count = c;
   endfunction

   function automatic logic [4:0][15:0] compact(input logic [7:0] m,
                                                input logic [4:0][15:0] v);
      logic [4:0][15:0] r;
      logic [2:0]       k;
      r = '0;
      k = 3'h0;
      for (int i = 0; i < NUM_ACH; i++) begin
         if (m[(i == SUPPLY_SLOT) ? SUPPLY_BIT : i]) begin
            r[k] = v[i];
            k = k + 3'h1;
         end
      end
      compact = r;
   endfunction

   function automatic logic [7:0] frame_byte(input iorx_sample_t s,
                                             input logic [4:0][15:0] al,
                                             input logic [7:0] len,
                                             input logic [5:0] p,
                                             input logic [5:0] last,
                                             input logic [7:0] sum);
      logic [5:0] d;
      logic [5:0] a;
      logic       dig;
      dig = (s.dig_mask != 16'h0000);
      d = p - POS_DATA;
      a = dig ? d - DIG_BYTES : d;
      if (p == last) begin
         frame_byte = CHK_BASE - sum;
      end else if (p == POS_DELIM) begin
         frame_byte = DELIM;
      end else if (p == POS_LEN_HI) begin
         frame_byte = LEN_HI;
      end else if (p == POS_LEN_LO) begin
         frame_byte = len;
      end else if (p == POS_TYPE) begin
         frame_byte = FTYPE;
      end else if (p <= POS_LADDR_E) begin
         frame_byte = s.long_addr[8*int'(POS_LADDR_E - p) +: 8];
      end else if (p <= POS_SADDR_E) begin
         frame_byte = s.net_addr[8*int'(POS_SADDR_E - p) +: 8];
      end else if (p == POS_OPTS) begin
         frame_byte = s.rx_opts;
      end else if (p == POS_NSAMP) begin
         frame_byte = NSAMP;
      end else if (p <= POS_DMASK_E) begin
         frame_byte = s.dig_mask[8*int'(POS_DMASK_E - p) +: 8];
      end else if (p == POS_AMASK) begin
         frame_byte = s.ana_mask;
      end else if (dig && d < DIG_BYTES) begin
         frame_byte = d[0] ? s.dig_val[7:0] : s.dig_val[15:8];
      end else begin
         frame_byte = a[0] ? al[a[3:1]][7:0] : al[a[3:1]][15:8];
      end
   endfunction

   // Unused mask bits and disabled digital lines forced to zero
   always_comb begin
      clean          = sample_i;
      clean.dig_mask = sample_i.dig_mask & DMASK_VALID;
      clean.ana_mask = sample_i.ana_mask & AMASK_VALID;
      clean.dig_val  = sample_i.dig_val & clean.dig_mask;
   end

   assign enabled   = mode_reg && (opt_reg == OPT_FRAMED);
   assign accept    = sample_valid_i && sample_ready_o;
   assign load      = (state_reg == ST_SEND) && (!tx_valid_o || tx_ready_i);
   assign last_pos  = len_reg[5:0] + POS_TYPE;
   assign next_byte = frame_byte(smp_reg, alist_reg, len_reg, pos_reg,
                                 last_pos, sum_reg);

   // Sample capture and frame sequencing
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg      <= ST_IDLE;
         sample_ready_o <= 1'b1;
         smp_reg        <= '0;
         alist_reg      <= '0;
         len_reg        <= 8'h00;
         pos_reg        <= 6'h00;
      end else if (accept && enabled) begin
         state_reg      <= ST_SEND;
         sample_ready_o <= 1'b0;
         smp_reg        <= clean;
         alist_reg      <= compact(clean.ana_mask, clean.ana_val);
         len_reg        <= LEN_FIXED
                         + ((clean.dig_mask != 16'h0000) ? 8'h02 : 8'h00)
                         + {4'h0, ana_count(clean.ana_mask), 1'b0};
         pos_reg        <= POS_DELIM;
      end else if (load) begin
         pos_reg <= pos_reg + 6'h01;
         if (pos_reg == last_pos) begin
            state_reg      <= ST_IDLE;
            sample_ready_o <= 1'b1;
         end
      end
   end

   // Output byte register, held while the sink stalls
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_valid_o  <= 1'b0;
         tx_data_o   <= 8'h00;
         out_pos_reg <= 6'h00;
      end else if (load) begin
         tx_valid_o  <= 1'b1;
         tx_data_o   <= next_byte;
         out_pos_reg <= pos_reg;
      end else if (tx_ready_i) begin
         tx_valid_o  <= 1'b0;
      end
   end

   // Running checksum over bytes 3 to last data
   always_ff @(posedge clk_i) begin
      if (reset_i || accept) begin
         sum_reg <= 8'h00;
      end else if (load && pos_reg >= POS_TYPE && pos_reg != last_pos) begin
         sum_reg <= sum_reg + next_byte;
      end
   end

   // Frame and drop counters
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         frames_reg <= 32'h0000_0000;
         drops_reg  <= 32'h0000_0000;
      end else begin
         if (load && pos_reg == last_pos) begin
            frames_reg <= frames_reg + 32'h0000_0001;
         end
         if (accept && !enabled) begin
            drops_reg <= drops_reg + 32'h0000_0001;
         end
      end
   end

   // APB slave: one wait-free access cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         apb_o <= '0;
      end else begin
         apb_o.pready  <= apb_i.psel && !apb_i.penable;
         apb_o.pslverr <= apb_i.psel && !apb_i.penable && !mapped(apb_i.paddr);
         if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
            unique case (apb_i.paddr)
               A_CTRL:   apb_o.prdata <= {16'h0000, opt_reg, 7'h00, mode_reg};
               A_STATUS: apb_o.prdata <= {16'h0000, len_reg, 6'h00, enabled,
                                          (state_reg == ST_SEND) || tx_valid_o};
               A_FRAMES: apb_o.prdata <= frames_reg;
               A_DROPS:  apb_o.prdata <= drops_reg;
               default:  apb_o.prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_reg <= MODE_RST;
         opt_reg  <= OPT_RST;
      end else if (apb_i.psel && apb_i.penable && apb_o.pready &&
                   apb_i.pwrite && apb_i.paddr == A_CTRL) begin
         mode_reg <= apb_i.pwdata[CTRL_MODE];
         opt_reg  <= apb_i.pwdata[CTRL_OPT +: 8];
      end
   end

   // Checksum of bytes actually handed over
   logic [7:0] chk_acc;
   logic       hs;
   assign hs = tx_valid_o && tx_ready_i;
   always_ff @(posedge clk_i) begin
      if (reset_i || (hs && out_pos_reg == POS_DELIM)) begin
         chk_acc <= 8'h00;
      end else if (hs && out_pos_reg >= POS_TYPE) begin
         chk_acc <= chk_acc + tx_data_o;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_delim;
      tx_valid_o && out_pos_reg == POS_DELIM |-> tx_data_o == DELIM;
   endproperty
   a_delim: assert property (p_delim)
      else $error("frame does not open with delimiter");

   property p_type;
      tx_valid_o && out_pos_reg == POS_TYPE |-> tx_data_o == FTYPE;
   endproperty
   a_type: assert property (p_type)
      else $error("wrong frame type byte");

   property p_len;
      hs && out_pos_reg == POS_LEN_HI |=> tx_valid_o
         && out_pos_reg == POS_LEN_LO && tx_data_o == len_reg;
   endproperty
   a_len: assert property (p_len)
      else $error("length low byte wrong or late");

   property p_len_val;
      state_reg == ST_SEND |-> len_reg == LEN_FIXED
         + ((smp_reg.dig_mask != 16'h0000) ? 8'h02 : 8'h00)
         + {4'h0, ana_count(smp_reg.ana_mask), 1'b0};
   endproperty
   a_len_val: assert property (p_len_val)
      else $error("length disagrees with masks");

   property p_nsamp;
      tx_valid_o && out_pos_reg == POS_NSAMP |-> tx_data_o == NSAMP;
   endproperty
   a_nsamp: assert property (p_nsamp)
      else $error("sample count not one");

   property p_dmask;
      tx_valid_o && out_pos_reg == POS_DMASK |-> (tx_data_o & 8'he3) == 8'h00;
   endproperty
   a_dmask: assert property (p_dmask)
      else $error("unused digital mask bit set");

   property p_amask;
      tx_valid_o && out_pos_reg == POS_AMASK |-> (tx_data_o & 8'h70) == 8'h00;
   endproperty
   a_amask: assert property (p_amask)
      else $error("unused analogue mask bit set");

   property p_dzero;
      tx_valid_o && out_pos_reg == POS_DATA && smp_reg.dig_mask != 16'h0000
         |-> (tx_data_o & ~smp_reg.dig_mask[15:8]) == 8'h00;
   endproperty
   a_dzero: assert property (p_dzero)
      else $error("disabled digital line reads nonzero");

   property p_chk;
      hs && out_pos_reg == last_pos |-> 8'(chk_acc + tx_data_o) == CHK_BASE;
   endproperty
   a_chk: assert property (p_chk)
      else $error("checksum wrong");

   property p_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
         && $stable(out_pos_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("byte dropped or changed under stall");

   property p_gate;
      accept && !enabled && state_reg == ST_IDLE |=> state_reg == ST_IDLE;
   endproperty
   a_gate: assert property (p_gate)
      else $error("frame started while disabled");

   property p_opts;
      tx_valid_o && out_pos_reg == POS_OPTS |-> tx_data_o == smp_reg.rx_opts;
   endproperty
   a_opts: assert property (p_opts)
      else $error("receive options byte wrong");

   property p_laddr;
      tx_valid_o && out_pos_reg == POS_LADDR
         |-> tx_data_o == smp_reg.long_addr[63:56];
   endproperty
   a_laddr: assert property (p_laddr)
      else $error("long address not sent MSB first");

   property p_saddr;
      tx_valid_o && out_pos_reg == POS_SADDR_E
         |-> tx_data_o == smp_reg.net_addr[7:0];
   endproperty
   a_saddr: assert property (p_saddr)
      else $error("network address low byte wrong");

   // No new sample taken while a frame is still being loaded
   property p_busy;
      state_reg == ST_SEND |-> !sample_ready_o;
   endproperty
   a_busy: assert property (p_busy)
      else $error("sample taken during frame");

   // Ready sink sees the next position in the very next cycle
   property p_gapless;
      hs && state_reg == ST_SEND && pos_reg == out_pos_reg + 6'h01
         |=> tx_valid_o && out_pos_reg == $past(pos_reg);
   endproperty
   a_gapless: assert property (p_gapless)
      else $error("gap or skip in byte stream");

   c_frame: cover property (hs && out_pos_reg == last_pos);
   c_dig:   cover property (hs && out_pos_reg == last_pos
                            && smp_reg.dig_mask != 16'h0000);
   c_ana:   cover property (hs && out_pos_reg == last_pos
                            && len_reg > LEN_FIXED + 8'h04);
   c_drop:  cover property (accept && !enabled);
   c_stall: cover property (tx_valid_o && !tx_ready_i [*3]);
endmodule
`default_nettype wire

/* File: rtl/iorx_pkg.sv */
// Constants and carriers for the I/O sample receive frame builder.
// Assumes one clock domain shared by sample source, byte sink and APB.
package iorx_pkg;
   // Frame bytes
   localparam logic [7:0]  DELIM       = 8'h7e;
   localparam logic [7:0]  FTYPE       = 8'h92;
   localparam logic [7:0]  NSAMP       = 8'h01;
   localparam logic [7:0]  CHK_BASE    = 8'hff;
   localparam logic [7:0]  LEN_HI      = 8'h00;
   // Byte positions
   localparam logic [5:0]  POS_DELIM   = 6'h00;
   localparam logic [5:0]  POS_LEN_HI  = 6'h01;
   localparam logic [5:0]  POS_LEN_LO  = 6'h02;
   localparam logic [5:0]  POS_TYPE    = 6'h03;
   localparam logic [5:0]  POS_LADDR   = 6'h04;
   localparam logic [5:0]  POS_LADDR_E = 6'h0b;
   localparam logic [5:0]  POS_SADDR   = 6'h0c;
   localparam logic [5:0]  POS_SADDR_E = 6'h0d;
   localparam logic [5:0]  POS_OPTS    = 6'h0e;
   localparam logic [5:0]  POS_NSAMP   = 6'h0f;
   localparam logic [5:0]  POS_DMASK   = 6'h10;
   localparam logic [5:0]  POS_DMASK_E = 6'h11;
   localparam logic [5:0]  POS_AMASK   = 6'h12;
   localparam logic [5:0]  POS_DATA    = 6'h13;
   localparam logic [5:0]  DIG_BYTES   = 6'h02;
   // Length of bytes 3..18, always present
   localparam logic [7:0]  LEN_FIXED   = 8'h10;
   // Channel masks
   localparam logic [15:0] DMASK_VALID = 16'h1cff;
   localparam logic [7:0]  AMASK_VALID = 8'h8f;
   localparam int          NUM_ACH     = 5;
   localparam int          SUPPLY_BIT  = 7;
   localparam int          SUPPLY_SLOT = 4;
   // APB map
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STATUS    = 8'h04;
   localparam logic [7:0]  A_FRAMES    = 8'h08;
   localparam logic [7:0]  A_DROPS     = 8'h0c;
   localparam int          CTRL_MODE   = 0;
   localparam int          CTRL_OPT    = 8;
   localparam logic        MODE_RST    = 1'b1;
   localparam logic [7:0]  OPT_RST     = 8'h00;
   localparam logic [7:0]  OPT_FRAMED  = 8'h00;

   typedef struct packed {
      logic [63:0]      long_addr;
      logic [15:0]      net_addr;
      logic [7:0]       rx_opts;
      logic [15:0]      dig_mask;
      logic [7:0]       ana_mask;
      logic [15:0]      dig_val;
      logic [4:0][15:0] ana_val;
   } iorx_sample_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } iorx_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } iorx_apb_rsp_t;
endpackage

/* File: tb/iorx_frame_builder_tb_top.sv */
// Self-checking bench for the I/O sample receive frame builder.
// Assumes one 200 MHz clock shared by sample source, host and APB master.
`timescale 1ns/10ps
`default_nettype none
module iorx_frame_builder_tb_top;
   import iorx_pkg::*;
   logic          clk_i;
   logic          reset_i;
   logic          sample_valid_i;
   iorx_sample_t  sample_i;
   logic          sample_ready_o;
   logic          tx_valid_o;
   logic [7:0]    tx_data_o;
   logic          tx_ready_i;
   logic          slow;
   int            bad;
   iorx_apb_req_t apb_i;
   iorx_apb_rsp_t apb_o;
   int            fail_count = 0;
   int            n_compared = 0;
   logic [7:0]    exp_q[$];
   logic [31:0]   rd;
   logic          er;
   iorx_sample_t  s;

   iorx_frame_builder i_dut (.clk_i(clk_i), .reset_i(reset_i),
      .sample_valid_i(sample_valid_i), .sample_i(sample_i),
      .sample_ready_o(sample_ready_o), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .apb_i(apb_i),
      .apb_o(apb_o));
   iorx_host_model i_host (.clk_i(clk_i), .reset_i(reset_i),
      .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i), .slow_i(slow), .bad_o(bad));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_i);
      apb_i.penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (apb_o.pready !== 1'b1);
      rd = apb_o.prdata;
      er = apb_o.pslverr;
      apb_i <= '0;
      @(posedge clk_i);
   endtask

   // Expected bytes appended for one sample
   function automatic void build(input iorx_sample_t x);
      logic [15:0] dm;
      logic [7:0]  am;
      logic [7:0]  sum;
      int          b;
      dm = x.dig_mask & DMASK_VALID;
      am = x.ana_mask & AMASK_VALID;
      b = exp_q.size();
      exp_q.push_back(8'h7e);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h92);
      for (int i = 7; i >= 0; i--) exp_q.push_back(x.long_addr[i*8 +: 8]);
      exp_q.push_back(x.net_addr[15:8]);
      exp_q.push_back(x.net_addr[7:0]);
      exp_q.push_back(x.rx_opts);
      exp_q.push_back(8'h01);
      exp_q.push_back(dm[15:8]);
      exp_q.push_back(dm[7:0]);
      exp_q.push_back(am);
      if (dm != 16'h0000) begin
         exp_q.push_back(x.dig_val[15:8] & dm[15:8]);
         exp_q.push_back(x.dig_val[7:0] & dm[7:0]);
      end
      for (int k = 0; k < 5; k++) begin
         if (am[k == 4 ? 7 : k]) begin
            exp_q.push_back(x.ana_val[k][15:8]);
            exp_q.push_back(x.ana_val[k][7:0]);
         end
      end
      exp_q[b + 2] = 8'(exp_q.size() - b - 3);
      sum = 8'h00;
      for (int i = b + 3; i < exp_q.size(); i++) sum += exp_q[i];
      exp_q.push_back(8'hff - sum);
   endfunction

   task automatic send(input iorx_sample_t x, input logic last);
      sample_valid_i <= 1'b1;
      sample_i <= x;
      do begin
         @(posedge clk_i);
      end while (sample_ready_o !== 1'b1);
      if (last) sample_valid_i <= 1'b0;
   endtask

   task automatic expect_bytes(input string name);
      int n;
      n = 0;
      while (i_host.rx_q.size() < exp_q.size() && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      repeat (4) @(posedge clk_i);
      chk(i_host.rx_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(i_host.rx_q[i], exp_q[i]);
      i_host.rx_q = {};
      exp_q = {};
      $display("test %s done", name);
   endtask

   task automatic t_regs();
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      $display("test regs done");
   endtask

   task automatic t_example();
      s = '0;
      s.long_addr = 64'h0013a200_40522baa;
      s.net_addr = 16'h7d84;
      s.rx_opts = 8'h01;
      s.dig_mask = 16'h001c;
      s.ana_mask = 8'h02;
      s.dig_val = 16'he314;
      s.ana_val[1] = 16'h0225;
      build(s);
      chk(exp_q[2], 8'h14);
      chk(exp_q[23], 8'hf5);
      send(s, 1'b1);
      expect_bytes("example");
   endtask

   task automatic t_full_b2b();
      slow <= 1'b1;
      s = '0;
      s.long_addr = 64'h0123_4567_89ab_cdef;
      s.net_addr = 16'hfffe;
      s.rx_opts = 8'h02;
      s.dig_mask = 16'hffff;
      s.ana_mask = 8'hff;
      s.dig_val = 16'hffff;
      for (int k = 0; k < 5; k++) s.ana_val[k] = 16'(16'h1011 * (k + 1));
      build(s);
      send(s, 1'b0);
      s.dig_mask = 16'he300;
      s.ana_mask = 8'h70;
      build(s);
      send(s, 1'b1);
      expect_bytes("full_b2b");
      slow <= 1'b0;
   endtask

   task automatic t_disabled();
      apb(1'b1, A_CTRL, 32'h0000_0000);
      send(s, 1'b1);
      apb(1'b1, A_CTRL, 32'h0000_0101);
      send(s, 1'b1);
      repeat (40) @(posedge clk_i);
      chk(i_host.rx_q.size(), 0);
      chk(sample_ready_o, 1'b1);
      apb(1'b0, A_DROPS, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, A_CTRL, 32'h0000_0001);
      t_example();
      chk(bad, 0);
      apb(1'b0, A_FRAMES, 32'h0);
      chk(rd, 32'h0000_0004);
      apb(1'b0, A_STATUS, 32'h0);
      chk(rd, 32'h0000_1402);
      $display("test disabled done");
   endtask

   initial begin
      reset_i = 1'b1;
      sample_valid_i = 1'b0;
      sample_i = '0;
      apb_i = '0;
      slow = 1'b0;
      s = '0;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_example();
      t_full_b2b();
      t_disabled();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      end_sim();
   end
endmodule
`default_nettype wire

/* File: tb/iorx_host_model.sv */
// Host controller reading the framed byte stream from the builder.
// Assumes the builder's clock and reset; slow_i makes it stall the stream.
`timescale 1ns/10ps
`default_nettype none
module iorx_host_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // Byte stream
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   // Control and status
   input  wire logic       slow_i,
   output int              bad_o
);
   logic [7:0] rx_q[$];
   logic [7:0] fr_q[$];
   logic [7:0] sum;
   int         cnt;

   // Ready one cycle in three when stalling
   always @(posedge clk_i) begin
      cnt <= reset_i ? 0 : (cnt == 2 ? 0 : cnt + 1);
      tx_ready_o <= !reset_i && (!slow_i || cnt == 2);
   end

   // Frame validation and discard
   always @(posedge clk_i) begin
      if (reset_i) begin
         fr_q = {};
         bad_o <= 0;
      end else if (tx_valid_i && tx_ready_o) begin
         rx_q.push_back(tx_data_i);
         fr_q.push_back(tx_data_i);
         if (fr_q[0] !== 8'h7e) begin
            bad_o <= bad_o + 1;
            fr_q = {};
         end else if (fr_q.size() > 3 && fr_q.size() == fr_q[2] + 4) begin
            sum = 8'h00;
            for (int i = 3; i < fr_q.size(); i++) sum += fr_q[i];
            if (sum !== 8'hff || fr_q[1] !== 8'h00) bad_o <= bad_o + 1;
            fr_q = {};
         end
      end
   end
endmodule
`default_nettype wire
